// *** rtl/dkc_pkg.sv ***
// constants, field layouts and state codes of the disk controller command block
package dkc_pkg;

  // ----------------------------------------------------------------
  // device select and timing
  // ----------------------------------------------------------------
  localparam logic [5:0]  DEV_CODE      = 6'h1B;
  localparam int          CLK_NS        = 40;
  localparam int          SEEK_START_US = 50;
  localparam logic [15:0] SEEK_CYC      = 16'((SEEK_START_US * 1000 + CLK_NS - 1) / CLK_NS);
  localparam int          LATE_NS       = 2000;
  localparam logic [15:0] LATE_CYC      = 16'(LATE_NS / CLK_NS);
  localparam int          HOLD_S        = 6;
  localparam longint      HOLD_CYC_L    = longint'(HOLD_S) * 64'd1000000000 / longint'(CLK_NS);

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam logic [8:0]  WORDS_PER_SECT = 9'h100;
  localparam logic [3:0]  LAST_SECTOR    = 4'hC;
  localparam logic [4:0]  LAST_HEAD      = 5'h01;
  localparam logic [15:0] WR_ADDR_ADJ    = 16'h0002;
  localparam logic [3:0]  COUNT_LAST     = 4'hF;

  // ----------------------------------------------------------------
  // function word (bus bit n is data bit 15-n)
  // ----------------------------------------------------------------
  localparam int FW_IRST   = 15;
  localparam int FW_CLRERR = 14;
  localparam int FW_MODE_H = 9;
  localparam int FW_MODE_L = 8;
  localparam int FW_CYL_H  = 7;

  // unit/head/sector/count word
  localparam int UH_UNIT_H = 14;
  localparam int UH_UNIT_L = 13;
  localparam int UH_HEAD_H = 12;
  localparam int UH_HEAD_L = 8;
  localparam int UH_SECT_H = 7;
  localparam int UH_SECT_L = 4;
  localparam int UH_CNT_H  = 3;

  // status word
  localparam int ST_RWDONE = 15;
  localparam int ST_SKDONE = 14;
  localparam int ST_SEEKNG = 10;
  localparam int ST_READY  = 6;
  localparam int ST_SKERR  = 5;
  localparam int ST_EOC    = 4;
  localparam int ST_ADDR   = 3;
  localparam int ST_CHK    = 2;
  localparam int ST_LATE   = 1;
  localparam int ST_ERR    = 0;

  // drive command codes carried by the mode bits
  localparam logic [1:0] MODE_READ  = 2'b00;
  localparam logic [1:0] MODE_WRITE = 2'b01;
  localparam logic [1:0] MODE_SEEK  = 2'b10;
  localparam logic [1:0] MODE_RECAL = 2'b11;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SKACK = 3'b001,
    ST_SKWT  = 3'b010,
    ST_PEND  = 3'b011,
    ST_RWACK = 3'b100,
    ST_SECT  = 3'b101,
    ST_XFER  = 3'b110,
    ST_NEXT  = 3'b111
  } dkc_state_e;

endpackage : dkc_pkg

// *** rtl/dkc_ctrl.sv ***
// disk controller command, status and data-channel logic with its data fifo
// Function
// R1 - respond only when device select equals octal 33
// R2 - pulse launches seek, busy and done untouched, 50 us start wait
// R3 - seek held up to 6 s or until read/write completion
// R4 - further seek accepted while a previous seek is held
// R5 - seek completion sets per-unit flag and raises interrupt
// R6 - start launches read/write; adapter occupied or drive not ready keeps it pending
// R7 - wait for sector, then channel request per read word or free write buffer
// R8 - checkword mismatch halts transfer; head and sector remain readable
// R9 - cylinder end with nonzero count sets end-of-cylinder, no automatic seek
// R10 - function load captures interrupt-reset, mode, cylinder, then performs function
// R11 - mode bits decode into drive command
// R12 - core address load takes accumulator bits 1 to 15
// R13 - unit/head/sector/count loaded from bits 1 to 15, count is negated
// R14 - status read returns state bits 0-9 and error bits 10-15
// R15 - bit 10 set when selected drive failed to finish seek; code sets it when any unit is still seeking at hold timeout
// R16 - bit 11 set when head passes last head; stops transfer
// R17 - bit 12 set on drive unsafe or header address mismatch
// R18 - bit 13 set on read checkword mismatch
// R19 - bit 14 set when channel acknowledge comes too late
// R20 - bit 15 is the OR of bits 10 to 14
// R21 - address counter readable; write of N sectors ends at start+256N+2
// R22 - unit/head/sector/count register readable in bits 1 to 15
// R23 - sector 12 with increment pending advances head, clears sector
// R24 - after start, wait for adapter select acknowledge
// R25 - count increments per sector; zero ends operation and sets done
`timescale 1ns/1ps

// ----------------------------------------------------------------
// data fifo
// ----------------------------------------------------------------
module dkc_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         flush,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic                full;
    logic                empty;
  } dkc_fifo_s;

  dkc_fifo_s q;
  dkc_fifo_s d;
  logic      push;
  logic      pop;

  assign push      = in_valid && !q.full;
  assign pop       = out_ready && !q.empty;
  assign in_ready  = !q.full;
  assign out_valid = !q.empty;
  assign out_data  = q.mem[q.rp];

  always_comb begin
    d = q;
    if (flush) begin
      d.wp  = '0;
      d.rp  = '0;
      d.cnt = '0;
    end else begin
      if (push) begin
        d.mem[q.wp] = in_data;
        d.wp        = q.wp + 1'b1;
      end
      if (pop) begin
        d.rp = q.rp + 1'b1;
      end
      if (push && !pop) begin
        d.cnt = q.cnt + 1'b1;
      end else if (pop && !push) begin
        d.cnt = q.cnt - 1'b1;
      end
    end
    d.full  = (d.cnt == (AW+1)'(D));
    d.empty = (d.cnt == '0);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q       <= '0;
      q.empty <= 1'b1;
    end else begin
      q <= d;
    end
  end

endmodule : dkc_fifo

// ----------------------------------------------------------------
// controller top
// ----------------------------------------------------------------
module dkc_ctrl
  import dkc_pkg::*;
#(
  parameter logic [27:0] HOLD_CYC = 28'(HOLD_CYC_L)
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // i/o bus
  input  wire logic [5:0]  io_sel,
  input  wire logic [15:0] io_data_in,
  input  wire logic        io_datoa,
  input  wire logic        io_datob,
  input  wire logic        io_datoc,
  input  wire logic        io_datia,
  input  wire logic        io_datib,
  input  wire logic        io_datic,
  input  wire logic        io_start,
  input  wire logic        io_clear,
  input  wire logic        io_pulse,
  output logic [15:0]      io_data_out,
  output logic             busy,
  output logic             done,
  output logic             int_req,
  // data channel
  output logic             dch_req,
  output logic             dch_to_mem,
  output logic [14:0]      dch_addr,
  output logic [15:0]      dch_wdata,
  input  wire logic [15:0] dch_rdata,
  input  wire logic        dch_ack,
  // adapter control
  output logic             adp_start,
  input  wire logic        adp_sel_ack,
  input  wire logic        adp_busy,
  output logic             adp_seek_go,
  output logic [1:0]       adp_cmd,
  output logic [7:0]       adp_cyl,
  output logic [1:0]       adp_unit,
  output logic [4:0]       adp_head,
  output logic [3:0]       adp_sector,
  // adapter status
  input  wire logic        drive_ready_bit,
  input  wire logic [3:0]  adp_seek_done,
  input  wire logic        adp_unsafe,
  input  wire logic        adp_addr_err,
  input  wire logic        adp_ckwd_err,
  input  wire logic        adp_sector_match,
  // adapter data
  input  wire logic        adp_rd_valid,
  output logic             adp_rd_ready,
  input  wire logic [15:0] adp_rd_data,
  output logic             adp_wr_valid,
  input  wire logic        adp_wr_ready,
  output logic [15:0]      adp_wr_data
);

  typedef struct packed {
    dkc_state_e  state;
    logic [7:0]  cyl;
    logic [1:0]  mode;
    logic [15:0] caddr;
    logic [1:0]  unit;
    logic [4:0]  head;
    logic [3:0]  sector;
    logic [3:0]  scount;
    logic        busy;
    logic        done;
    logic [3:0]  seek_done;
    logic [3:0]  seeking;
    logic        err_seek;
    logic        err_eoc;
    logic        err_addr;
    logic        err_chk;
    logic        err_late;
    logic [15:0] tmr;
    logic        hold;
    logic [27:0] hold_tmr;
    logic [8:0]  wcnt;
    logic        dch_req;
    logic        dch_to_mem;
    logic [15:0] dch_wdata;
    logic        adp_start;
    logic        adp_seek_go;
    logic [15:0] io_dout;
    logic        int_req;
  } dkc_st_s;

  dkc_st_s     q;
  dkc_st_s     d;
  logic        sel;
  logic        is_wr;
  logic        fin;
  logic        f_in_valid;
  logic        f_in_ready;
  logic [15:0] f_in_data;
  logic        f_out_valid;
  logic        f_out_ready;
  logic [15:0] f_out_data;
  logic        f_flush;
  logic [15:0] status;

  assign sel     = (io_sel == DEV_CODE); // R1
  assign is_wr   = (q.mode == MODE_WRITE);
  assign f_flush = (q.state == ST_IDLE);

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  always_comb begin
    status             = '0;
    status[ST_RWDONE]  = q.done; // R14
    for (int u = 0; u < 4; u++) begin
      status[ST_SKDONE-u] = q.seek_done[u];
      status[ST_SEEKNG-u] = q.seeking[u];
    end
    status[ST_READY]   = drive_ready_bit;
    status[ST_SKERR]   = q.err_seek; // R15
    status[ST_EOC]     = q.err_eoc; // R16
    status[ST_ADDR]    = q.err_addr; // R17
    status[ST_CHK]     = q.err_chk; // R18
    status[ST_LATE]    = q.err_late; // R19
    status[ST_ERR]     = q.err_seek | q.err_eoc | q.err_addr | q.err_chk | q.err_late; // R20
  end

  // ----------------------------------------------------------------
  // fifo path selection
  // ----------------------------------------------------------------
  always_comb begin
    f_in_valid  = 1'b0;
    f_in_data   = adp_rd_data;
    f_out_ready = 1'b0;
    if (q.state == ST_XFER) begin
      if (is_wr) begin
        f_in_valid  = dch_ack && q.dch_req;
        f_in_data   = dch_rdata;
        f_out_ready = adp_wr_ready;
      end else begin
        f_in_valid  = adp_rd_valid;
        f_out_ready = !q.dch_req && (q.wcnt != WORDS_PER_SECT);
      end
    end
  end

  assign adp_rd_ready = f_in_ready && !is_wr && (q.state == ST_XFER);
  assign adp_wr_valid = f_out_valid && is_wr && (q.state == ST_XFER);
  assign adp_wr_data  = f_out_data;

  dkc_fifo #(
    .W (16),
    .D (8)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .flush     (f_flush),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // ----------------------------------------------------------------
  // command, transfer and status logic
  // ----------------------------------------------------------------
  always_comb begin
    d             = q;
    fin           = 1'b0;
    d.adp_seek_go = 1'b0;
    d.io_dout     = '0;
    if (sel && io_datia) d.io_dout = status; // R14
    if (sel && io_datib) d.io_dout = q.caddr; // R21
    if (sel && io_datic) d.io_dout = {1'b0, q.unit, q.head, q.sector, q.scount}; // R22
    if (sel && io_datoa) begin
      d.mode = io_data_in[FW_MODE_H:FW_MODE_L]; // R10 R11
      d.cyl  = io_data_in[FW_CYL_H:0]; // R10
      if (io_data_in[FW_IRST]) d.seek_done = '0; // R10
      if (io_data_in[FW_CLRERR]) begin
        d.err_seek = 1'b0;
        d.err_eoc  = 1'b0;
        d.err_addr = 1'b0;
        d.err_chk  = 1'b0;
        d.err_late = 1'b0;
      end
    end
    if (sel && io_datob) d.caddr = {1'b0, io_data_in[14:0]}; // R12
    if (sel && io_datoc) begin
      d.unit   = io_data_in[UH_UNIT_H:UH_UNIT_L]; // R13
      d.head   = io_data_in[UH_HEAD_H:UH_HEAD_L];
      d.sector = io_data_in[UH_SECT_H:UH_SECT_L];
      d.scount = io_data_in[UH_CNT_H:0];
    end
    if (q.hold) begin
      d.hold_tmr = q.hold_tmr + 1'b1;
      if (q.hold_tmr == HOLD_CYC - 1'b1) begin
        d.hold = 1'b0; // R3
        if (|q.seeking) d.err_seek = 1'b1; // R15
        d.seeking = '0;
      end
    end
    if (sel && io_clear) begin
      d.busy = 1'b0;
      d.done = 1'b0;
      if (q.state != ST_SKACK && q.state != ST_SKWT) d.state = ST_IDLE;
    end else begin
      unique case (q.state)
        ST_IDLE: begin
          if (sel && io_pulse) begin
            d.seeking[q.unit] = 1'b1; // R2 R4
            d.hold            = 1'b1;
            d.hold_tmr        = '0;
            d.adp_start       = 1'b1;
            d.state           = ST_SKACK;
          end else if (sel && io_start) begin
            d.busy  = 1'b1; // R6
            d.done  = 1'b0;
            d.state = ST_PEND;
          end
        end
        ST_SKACK: begin
          if (adp_sel_ack) begin
            d.adp_start = 1'b0; // R24
            d.tmr       = '0;
            d.state     = ST_SKWT;
          end
        end
        ST_SKWT: begin
          d.tmr = q.tmr + 1'b1;
          if (q.tmr == SEEK_CYC - 1'b1) begin
            d.adp_seek_go = 1'b1; // R2
            d.state       = ST_IDLE;
          end
        end
        ST_PEND: begin
          if (!adp_busy && drive_ready_bit) begin
            d.adp_start = 1'b1; // R6
            d.state     = ST_RWACK;
          end
        end
        ST_RWACK: begin
          if (adp_sel_ack) begin
            d.adp_start = 1'b0; // R24
            d.wcnt      = '0;
            d.state     = ST_SECT;
          end
        end
        ST_SECT: begin
          if (adp_unsafe || adp_addr_err) begin
            d.err_addr = 1'b1; // R17
            fin        = 1'b1;
          end else if (adp_sector_match) begin
            d.state = ST_XFER; // R7
          end
        end
        ST_XFER: begin
          if (!is_wr && !q.dch_req && f_out_valid && q.wcnt != WORDS_PER_SECT) begin
            d.dch_req    = 1'b1; // R7
            d.dch_to_mem = 1'b1;
            d.dch_wdata  = f_out_data;
            d.tmr        = '0;
          end
          if (is_wr && !q.dch_req && f_in_ready && q.wcnt != WORDS_PER_SECT) begin
            d.dch_req    = 1'b1; // R7
            d.dch_to_mem = 1'b0;
            d.tmr        = '0;
          end
          if (q.dch_req && dch_ack) begin
            d.dch_req = 1'b0;
            d.caddr   = q.caddr + 1'b1;
            d.wcnt    = q.wcnt + 1'b1;
          end else if (q.dch_req) begin
            d.tmr = q.tmr + 1'b1;
            if (q.tmr == LATE_CYC - 1'b1) begin
              d.err_late = 1'b1; // R19
              fin        = 1'b1;
            end
          end
          if (adp_unsafe || adp_addr_err) begin
            d.err_addr = 1'b1; // R17
            fin        = 1'b1;
          end
          if (!is_wr && adp_ckwd_err) begin
            d.err_chk = 1'b1; // R8 R18
            fin       = 1'b1;
          end
          if (!fin && q.wcnt == WORDS_PER_SECT && !q.dch_req && (!is_wr || !f_out_valid)) begin
            d.state = ST_NEXT;
          end
        end
        ST_NEXT: begin
          d.scount = q.scount + 1'b1; // R25
          d.wcnt   = '0;
          if (q.scount == COUNT_LAST) begin
            if (is_wr) d.caddr = q.caddr + WR_ADDR_ADJ; // R21
            fin = 1'b1; // R25
          end else if (q.sector == LAST_SECTOR) begin
            if (q.head == LAST_HEAD) begin
              d.scount  = q.scount;
              d.err_eoc = 1'b1; // R9 R16
              fin       = 1'b1;
            end else begin
              d.sector = '0; // R23
              d.head   = q.head + 1'b1;
              d.state  = ST_SECT;
            end
          end else begin
            d.sector = q.sector + 1'b1;
            d.state  = ST_SECT;
          end
        end
      endcase
    end
    if (fin) begin
      d.state   = ST_IDLE;
      d.busy    = 1'b0;
      d.done    = 1'b1; // R25
      d.dch_req = 1'b0;
      d.hold    = 1'b0; // R3
    end
    for (int u = 0; u < 4; u++) begin
      if (q.seeking[u] && adp_seek_done[u]) begin
        d.seek_done[u] = 1'b1; // R5
        d.seeking[u]   = 1'b0;
      end
    end
    d.int_req = d.done | (|d.seek_done); // R5
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign io_data_out = q.io_dout;
  assign busy        = q.busy;
  assign done        = q.done;
  assign int_req     = q.int_req;
  assign dch_req     = q.dch_req;
  assign dch_to_mem  = q.dch_to_mem;
  assign dch_addr    = q.caddr[14:0];
  assign dch_wdata   = q.dch_wdata;
  assign adp_start   = q.adp_start;
  assign adp_seek_go = q.adp_seek_go;
  assign adp_cmd     = q.mode;
  assign adp_cyl     = q.cyl;
  assign adp_unit    = q.unit;
  assign adp_head    = q.head;
  assign adp_sector  = q.sector;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_foreign_select: assert property ((io_datoa || io_datob) && !sel |=> $stable(q.cyl) && $stable(q.caddr)) // R1
    else $error("foreign select code changed a register");
  a_seek_flags: assert property (q.state == ST_IDLE && sel && io_pulse && !io_clear
                                 |=> $stable(q.busy) && $stable(q.done) && q.state == ST_SKACK) // R2
    else $error("seek launch touched busy or done");
  a_seek_delay: assert property ($rose(q.adp_seek_go) |-> $past(q.tmr) == SEEK_CYC - 1'b1) // R2
    else $error("seek issued before start wait elapsed");
  a_seek_int: assert property (q.seeking[0] && adp_seek_done[0] |=> q.seek_done[0] && q.int_req) // R5
    else $error("seek completion did not raise flag and interrupt");
  a_start_pend: assert property (q.state == ST_IDLE && sel && io_start && !io_pulse && !io_clear
                                 |=> q.busy && q.state == ST_PEND) // R6
    else $error("start did not set busy and pend");
  a_ack_wait: assert property (q.state == ST_RWACK && !adp_sel_ack && !(sel && io_clear)
                               |=> q.state == ST_RWACK && q.adp_start) // R24
    else $error("controller moved on without adapter acknowledge");
  a_late_flag: assert property (q.state == ST_XFER && q.dch_req && !dch_ack && q.tmr == LATE_CYC - 1'b1
                                && !(sel && io_clear) |=> q.err_late && q.state == ST_IDLE) // R19
    else $error("late acknowledge not flagged");
  a_err_or: assert property (sel && io_datia |=> q.io_dout[ST_ERR] == ($past(q.err_seek) | $past(q.err_eoc)
                             | $past(q.err_addr) | $past(q.err_chk) | $past(q.err_late))) // R20
    else $error("summary error bit wrong");
  a_sector_wrap: assert property (q.state == ST_NEXT && q.scount != COUNT_LAST && q.sector == LAST_SECTOR
                                  && q.head != LAST_HEAD && !(sel && (io_clear || io_datoc))
                                  |=> q.sector == '0 && q.head == $past(q.head) + 1'b1) // R23
    else $error("sector wrap did not advance head");
  a_end_cyl: assert property (q.state == ST_NEXT && q.scount != COUNT_LAST && q.sector == LAST_SECTOR
                              && q.head == LAST_HEAD && !(sel && io_clear) |=> q.err_eoc && q.state == ST_IDLE) // R9
    else $error("end of cylinder not flagged");
  a_count_done: assert property (q.state == ST_NEXT && q.scount == COUNT_LAST && !(sel && io_clear)
                                 |=> q.done && !q.busy) // R25
    else $error("zero count did not end operation");
  a_chk_stop: assert property (q.state == ST_XFER && !is_wr && adp_ckwd_err && !(sel && (io_clear || io_datoc))
                               |=> q.err_chk && q.state == ST_IDLE && $stable(q.head) && $stable(q.sector)) // R8
    else $error("checkword error did not halt transfer");

  c_seek_done: cover property (q.seeking[0] ##1 q.seek_done[0]);
  c_rw_done: cover property (q.state == ST_NEXT ##1 q.done && !q.err_eoc);
  c_end_cyl: cover property ($rose(q.err_eoc));
  c_late: cover property ($rose(q.err_late));

endmodule : dkc_ctrl

// *** testbench/dkc_chan_model.sv ***
// data channel model answering controller requests
`timescale 1ns/1ps
module dkc_chan_model (
  // clock and reset
  input  wire logic   clk_sys,
  input  wire logic   rst_n,
  // channel
  input  wire logic   dch_req,
  input  wire logic   stall,
  output logic        dch_ack,
  output logic [15:0] dch_rdata,
  output int          n_ack
);
  // one ack per request, none while stalled; data line churns when idle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dch_ack   <= 1'b0;
      dch_rdata <= 16'h0000;
      n_ack     <= 0;
    end else if (dch_req && !dch_ack && !stall) begin
      dch_ack   <= 1'b1;
      dch_rdata <= 16'(n_ack) ^ 16'hA5A5;
      n_ack     <= n_ack + 1;
    end else begin
      dch_ack   <= 1'b0;
      dch_rdata <= ~dch_rdata;
    end
  end
endmodule : dkc_chan_model

// *** testbench/tb_disk_controller_io_command.sv ***
// testbench of the disk controller command block
`timescale 1ns/1ps
module tb_disk_controller_io_command;
  import dkc_pkg::*;
  typedef struct {logic [5:0] sel; int ld; logic [15:0] d; int rd; logic [15:0] e;} dkc_row_s;
  logic        clk_sys, rst_n, adp_sel_ack, adp_busy, drive_ready_bit, adp_sector_match, adp_wr_ready, stall, rdv;
  logic        busy, done, int_req, dch_req, dch_to_mem, dch_ack, adp_start, adp_seek_go, adp_rd_ready, adp_wr_valid;
  logic [8:0]  s;
  logic [5:0]  io_sel;
  logic [15:0] io_data_in, io_data_out, dch_rdata, dch_wdata, adp_wr_data, v;
  logic [14:0] dch_addr;
  logic [7:0]  adp_cyl;
  logic [4:0]  adp_head;
  logic [3:0]  adp_seek_done, adp_sector;
  logic [1:0]  adp_cmd, adp_unit;
  int          n_fail, n_tests, n_ack, cyc, n, n_wr;
  dkc_row_s    rows[6] = '{'{DEV_CODE, 1, 16'h8123, 4, 16'h0123}, '{DEV_CODE, 2, 16'hFFFF, 5, 16'h7FFF},
                           '{6'h1A, 1, 16'h1234, 4, 16'h0123}, '{DEV_CODE, 1, 16'h0100, 4, 16'h0100},
                           '{DEV_CODE, 2, 16'h000F, 5, 16'h000F}, '{DEV_CODE, 0, 16'h0200, 3, 16'h0040}};

  dkc_ctrl #(.HOLD_CYC(28'd2000)) u_dkc_ctrl (.clk_sys, .rst_n, .io_sel, .io_data_in, .io_datoa(s[0]),
    .io_datob(s[1]), .io_datoc(s[2]), .io_datia(s[3]), .io_datib(s[4]), .io_datic(s[5]), .io_start(s[6]),
    .io_clear(s[8]), .io_pulse(s[7]), .io_data_out, .busy, .done, .int_req, .dch_req, .dch_to_mem, .dch_addr,
    .dch_wdata, .dch_rdata, .dch_ack, .adp_start, .adp_sel_ack, .adp_busy, .adp_seek_go, .adp_cmd, .adp_cyl,
    .adp_unit, .adp_head, .adp_sector, .drive_ready_bit, .adp_seek_done, .adp_unsafe(1'b0),
    .adp_addr_err(1'b0), .adp_ckwd_err(1'b0), .adp_sector_match, .adp_rd_valid(rdv), .adp_rd_ready(),
    .adp_rd_data(16'h5A5A), .adp_wr_valid, .adp_wr_ready, .adp_wr_data);
  dkc_chan_model u_dkc_chan_model (.clk_sys, .rst_n, .dch_req, .stall, .dch_ack, .dch_rdata, .n_ack);

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic op(input int k, input logic [15:0] d, input logic [5:0] sl = DEV_CODE);
    @(posedge clk_sys);
    s          <= 9'h001 << k;
    io_data_in <= d;
    io_sel     <= sl;
    @(posedge clk_sys);
    s <= 9'h000;
    #1 v = io_data_out;
  endtask : op
  task automatic ackst();
    @(posedge clk_sys iff adp_start);
    adp_sel_ack <= 1'b1;
    @(posedge clk_sys);
    adp_sel_ack <= 1'b0;
  endtask : ackst
  task automatic pulse_match();
    @(posedge clk_sys);
    adp_sector_match <= 1'b1;
    @(posedge clk_sys);
    adp_sector_match <= 1'b0;
  endtask : pulse_match
  task automatic seek();
    op(7, 16'h0000);
    ackst();
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (!adp_seek_go && n < 2000);
    chk(16'(n), SEEK_CYC);
    chk({busy, done}, 2'b00);
    @(posedge clk_sys);
    adp_seek_done <= 4'h1;
    @(posedge clk_sys);
    adp_seek_done <= 4'h0;
    #1 chk(int_req, 1'b1);
  endtask : seek
  task automatic conclude();
    $display("tests=%0d failures=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // clock, timeout and sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (adp_wr_valid && adp_wr_ready) begin
      chk(adp_wr_data, 16'(n_wr) ^ 16'hA5A5);
      n_wr++;
    end
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    {rst_n, adp_sel_ack, adp_busy, adp_sector_match, stall, rdv, s, io_data_in, adp_seek_done} = '0;
    {drive_ready_bit, adp_wr_ready, io_sel} = {2'b11, DEV_CODE};
    repeat (16) @(posedge clk_sys);
    chk({busy, done, int_req, dch_req, adp_start, adp_seek_go}, 6'h00);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      op(rows[i].ld, rows[i].d, rows[i].sel);
      op(rows[i].rd, 16'h0000);
      chk(v, rows[i].e);
    end
    chk({adp_cmd, adp_cyl}, {MODE_SEEK, 8'h00});
    seek();
    seek();
    op(3, 16'h0000);
    chk(v, 16'h4040);
    op(0, 16'h8100);
    chk({int_req, adp_cmd}, {1'b0, MODE_WRITE});
    @(posedge clk_sys) adp_busy <= 1'b1;
    op(6, 16'h0000);
    repeat (20) @(posedge clk_sys);
    #1 chk({busy, done, adp_start}, 3'b100);
    @(posedge clk_sys) adp_busy <= 1'b0;
    ackst();
    pulse_match();
    @(posedge clk_sys iff done);
    op(4, 16'h0000);
    chk(v, 16'h0202);
    chk(16'(n_ack), 16'd256);
    chk(16'(n_wr), 16'd256);
    op(2, 16'h000F);
    stall <= 1'b1;
    op(6, 16'h0000);
    ackst();
    pulse_match();
    repeat (80) @(posedge clk_sys);
    op(3, 16'h0000);
    chk(v[1:0], 2'b11);
    op(0, 16'h4200);
    stall <= 1'b0;
    op(7, 16'h0000);
    ackst();
    repeat (2100) @(posedge clk_sys);
    op(3, 16'h0000);
    chk(v[5:0], 6'h21);
    op(0, 16'h4000);
    op(2, 16'h00CE);
    rdv <= 1'b1;
    op(6, 16'h0000);
    ackst();
    pulse_match();
    @(posedge clk_sys iff adp_head == 5'h01);
    pulse_match();
    @(posedge clk_sys iff done);
    op(4, 16'h0000);
    chk(v, 16'h0402);
    op(5, 16'h0000);
    chk(v, 16'h0100);
    chk(dch_wdata, 16'h5A5A);
    chk(dch_to_mem, 1'b1);
    chk(dch_addr, 15'h0402);
    op(2, 16'h01CE);
    op(6, 16'h0000);
    ackst();
    pulse_match();
    @(posedge clk_sys iff done);
    op(3, 16'h0000);
    chk(v[5:0], 6'h11);
    op(5, 16'h0000);
    chk(v, 16'h01CE);
    conclude();
  end
endmodule : tb_disk_controller_io_command
